// File: hdl/smbus_temp_pkg.sv
package smbus_temp_pkg;

    // Register pointers carried by the command byte
    localparam logic [7:0] PTR_TEMP        = 8'h01;
    localparam logic [7:0] PTR_CONFIG      = 8'h03;
    localparam logic [7:0] PTR_MAKER       = 8'hFE;
    localparam logic [7:0] PTR_REV         = 8'hFF;
    localparam logic [7:0] PTR_RESET       = 8'h00;

    // Slave address: fixed upper nibble, three build-time variant bits
    localparam logic [3:0] ADDR_HIGH       = 4'h9;

    // Reset values and codes
    localparam logic [7:0] CONFIG_RESET    = 8'h80;
    localparam logic [7:0] TEMP_RESET      = 8'h00;
    localparam logic [7:0] TEMP_FULL_SCALE = 8'h7F;
    localparam logic [7:0] READ_FILL       = 8'h00;
    localparam int         POWER_DOWN_POS  = 6;

    // Serial framing
    localparam logic [3:0] BIT_LAST        = 4'h7;
    localparam logic [3:0] ACK_SLOT        = 4'h8;
    localparam logic [2:0] TX_LAST         = 3'h7;

    // Timing at ref_clk rate
    localparam int CLK_KHZ          = 100000;
    localparam int CONV_TIME_MS     = 200;
    localparam int CONV_TIME_MAX_MS = 240;
    localparam int CONV_CYCLES      = CONV_TIME_MS * CLK_KHZ;
    localparam int CONV_W           = 25;
    localparam int STALL_LIMIT_MS   = 30;
    localparam int STALL_CYCLES     = STALL_LIMIT_MS * CLK_KHZ;
    localparam int STALL_W          = 22;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_CMD,
        ST_DATA,
        ST_ACK_WAIT,
        ST_ACK,
        ST_TX,
        ST_SKIP
    } link_state_e;

endpackage

// File: hdl/sync2.sv
`timescale 1ns/1ns
module sync2 #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sync_s;

    sync_s r;
    sync_s next_r;

    // First stage feeds only the second
    always_comb begin
        next_r    = r;
        next_r.s1 = d;
        next_r.s2 = r.s1;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign q = r.s2;
endmodule

// File: hdl/conv_sequencer.sv
`timescale 1ns/1ns
module conv_sequencer #(
    parameter int CONV_CYCLES = smbus_temp_pkg::CONV_CYCLES
) (
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic       run,
    input  wire logic [7:0] adc_code,
    input  wire logic       adc_fault,
    output logic      [7:0] result,
    output logic            busy
);
    typedef struct packed {
        logic [smbus_temp_pkg::CONV_W-1:0] cnt;
        logic [7:0]                        result;
        logic                              busy;
    } seq_s;

    seq_s r;
    seq_s next_r;

    always_comb begin
        next_r = r;
        if (!run) begin
            // Abort drops the partial conversion; result keeps its old value
            next_r.cnt  = '0; // [R13] [R14] [R16]
            next_r.busy = 1'b0;
        end else begin
            next_r.busy = 1'b1;
            if (r.cnt == smbus_temp_pkg::CONV_W'(CONV_CYCLES - 1)) begin // [R15]
                next_r.cnt = '0; // [R19]
                // Whole byte loaded in one edge, so a read never sees a mix
                if (adc_fault) begin
                    next_r.result = smbus_temp_pkg::TEMP_FULL_SCALE; // [R11] [R12]
                end else begin
                    next_r.result = adc_code; // [R09] [R10]
                end
            end else begin
                next_r.cnt = r.cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            r <= '{cnt: '0, result: smbus_temp_pkg::TEMP_RESET, busy: 1'b0}; // [R18]
        end else begin
            r <= next_r;
        end
    end

    assign result = r.result;
    assign busy   = r.busy;
endmodule

// File: hdl/smbus_remote_temp_sensor.sv
`timescale 1ns/1ns
// How it works
// [R01] Write: address, command, data stored
// [R02] Read: address, command, restart, address, byte out
// [R03] Whole byte after write address is pointer
// [R04] Pointers 01,03,FE,FF; only 03 writable
// [R05] Host uses only the four pointers
// [R06] Revision byte holds die revision low nibble
// [R07] Answer only our own seven-bit address
// [R08] Address is 1001 plus three build bits
// [R09] Result is signed byte, one degree steps
// [R10] Codes span 80h to 7Fh, zero 00h
// [R11] Sensing fault loads full scale 7Fh
// [R12] Fault shows only after a conversion ends
// [R13] Shutdown bit halts converter, no new conversions
// [R14] Shutdown leaves all registers unchanged
// [R15] Conversion ends within 240 ms, nominal 200
// [R16] Config write aborts conversion, restarts after transaction
// [R17] Bit 6 set means shutdown, others reserved
// [R18] Result is zero until first conversion
// [R19] Back-to-back conversions, atomic result update
// [R20] Clock low too long abandons transaction
module smbus_remote_temp_sensor #(
    parameter logic [2:0] ADDR_SEL     = 3'h0,
    parameter logic [7:0] MAKER_CODE   = 8'h5C, // Arbitrary value
    parameter logic [3:0] DIE_REV      = 4'h0,  // Arbitrary value
    parameter int         CONV_CYCLES  = smbus_temp_pkg::CONV_CYCLES,
    parameter int         STALL_CYCLES = smbus_temp_pkg::STALL_CYCLES
) (
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic       scl,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe,
    input  wire logic [7:0] adc_code,
    input  wire logic       adc_fault,
    output logic            converter_on
);
    ////////////////////////////////////////////////////////////////////////
    // Serial clock domain: bit capture

    typedef struct packed {
        logic [3:0] bit_cnt;
        logic [6:0] shreg;
        logic [7:0] byte_hold;
    } link_s;

    typedef struct packed {
        smbus_temp_pkg::link_state_e state;
        smbus_temp_pkg::link_state_e after_ack;
        logic                        scl_d;
        logic                        sda_d;
        logic                        tgl_d;
        logic                        frame_clr;
        logic                        sda_oe;
        logic                        sda_o;
        logic [7:0]                  pointer;
        logic [7:0]                  tx;
        logic [2:0]                  tx_cnt;
        logic [7:0]                  config_reg;
        logic                        cfg_hold;
        logic [smbus_temp_pkg::STALL_W-1:0] stall;
    } core_s;

    link_s      l;
    link_s      next_l;
    logic       byte_tgl;
    logic       scl_rst;
    core_s      c;
    core_s      next_c;
    logic       scl_s;
    logic       sda_s;
    logic       tgl_s;
    logic [7:0] temp_result;
    logic       conv_busy;
    logic       conv_run;

    // Start or restart realigns the bit counter; no scl edge falls near it
    assign scl_rst = rst | c.frame_clr;

    always_comb begin
        next_l       = l;
        next_l.shreg = {l.shreg[5:0], sda_i};
        if (l.bit_cnt == smbus_temp_pkg::BIT_LAST) begin
            next_l.byte_hold = {l.shreg, sda_i};
        end
        if (l.bit_cnt == smbus_temp_pkg::ACK_SLOT) begin
            next_l.bit_cnt = '0;
        end else begin
            next_l.bit_cnt = l.bit_cnt + 1'b1;
        end
    end

    always_ff @(posedge scl or posedge scl_rst) begin
        if (scl_rst) begin
            l <= '0;
        end else begin
            l <= next_l;
        end
    end

    // Kept out of the frame reset so that a restart raises no false byte event
    always_ff @(posedge scl or posedge rst) begin
        if (rst) begin
            byte_tgl <= 1'b0;
        end else if (l.bit_cnt == smbus_temp_pkg::BIT_LAST) begin
            byte_tgl <= ~byte_tgl;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Crossings into ref_clk

    sync2 #(.W(3)) pin_sync (
        .clk (ref_clk),
        .rst (rst),
        .d   ({scl, sda_i, byte_tgl}),
        .q   ({scl_s, sda_s, tgl_s})
    );

    ////////////////////////////////////////////////////////////////////////
    // Register read multiplexer

    logic [7:0] rd_byte;
    logic [6:0] own_addr;
    logic       addr_match;

    // Undefined pointers read as a fixed fill; a well-behaved host never sends them
    always_comb begin
        case (c.pointer) // [R04]
            smbus_temp_pkg::PTR_TEMP: begin
                rd_byte = temp_result;
            end
            smbus_temp_pkg::PTR_CONFIG: begin
                rd_byte = c.config_reg;
            end
            smbus_temp_pkg::PTR_MAKER: begin
                rd_byte = MAKER_CODE;
            end
            smbus_temp_pkg::PTR_REV: begin
                rd_byte = {4'h0, DIE_REV}; // [R06]
            end
            default: begin
                rd_byte = smbus_temp_pkg::READ_FILL;
            end
        endcase
    end

    // Variant bits are fixed per build, so the match is against a constant
    // byte_hold is steady for a whole byte after its toggle, so it is read directly
    assign own_addr   = {smbus_temp_pkg::ADDR_HIGH, ADDR_SEL}; // [R08]
    assign addr_match = (l.byte_hold[7:1] == own_addr); // [R07]

    ////////////////////////////////////////////////////////////////////////
    // Transaction engine

    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    logic byte_evt;

    assign scl_fall   = c.scl_d & ~scl_s;
    assign start_cond = scl_s & c.scl_d & c.sda_d & ~sda_s;
    assign stop_cond  = scl_s & c.scl_d & ~c.sda_d & sda_s;
    assign byte_evt   = tgl_s ^ c.tgl_d;

    always_comb begin
        next_c           = c;
        next_c.scl_d     = scl_s;
        next_c.sda_d     = sda_s;
        next_c.tgl_d     = tgl_s;
        next_c.frame_clr = 1'b0;
        case (c.state)
            smbus_temp_pkg::ST_ADDR: begin
                if (byte_evt) begin
                    if (addr_match) begin // [R07]
                        next_c.state     = smbus_temp_pkg::ST_ACK_WAIT;
                        next_c.after_ack = l.byte_hold[0] ? smbus_temp_pkg::ST_TX // [R02]
                                                          : smbus_temp_pkg::ST_CMD; // [R01]
                    end else begin
                        next_c.state = smbus_temp_pkg::ST_SKIP; // [R07]
                    end
                end
            end
            smbus_temp_pkg::ST_CMD: begin
                if (byte_evt) begin
                    next_c.pointer   = l.byte_hold; // [R03]
                    next_c.state     = smbus_temp_pkg::ST_ACK_WAIT;
                    next_c.after_ack = smbus_temp_pkg::ST_DATA;
                end
            end
            smbus_temp_pkg::ST_DATA: begin
                if (byte_evt) begin
                    // Read-only pointers acknowledge but drop the byte
                    if (c.pointer == smbus_temp_pkg::PTR_CONFIG) begin // [R04]
                        next_c.config_reg = l.byte_hold; // [R01] [R17]
                        next_c.cfg_hold   = 1'b1; // [R16]
                    end
                    next_c.state     = smbus_temp_pkg::ST_ACK_WAIT;
                    next_c.after_ack = smbus_temp_pkg::ST_SKIP;
                end
            end
            smbus_temp_pkg::ST_ACK_WAIT: begin
                if (scl_fall) begin
                    next_c.sda_oe = 1'b1;
                    next_c.state  = smbus_temp_pkg::ST_ACK;
                end
            end
            smbus_temp_pkg::ST_ACK: begin
                if (scl_fall) begin
                    next_c.sda_oe = 1'b0;
                    next_c.state  = c.after_ack;
                    if (c.after_ack == smbus_temp_pkg::ST_TX) begin
                        next_c.tx     = rd_byte; // [R02]
                        next_c.sda_oe = ~rd_byte[7];
                        next_c.tx_cnt = '0;
                    end
                end
            end
            smbus_temp_pkg::ST_TX: begin
                if (scl_fall) begin
                    if (c.tx_cnt == smbus_temp_pkg::TX_LAST) begin
                        // Host acknowledge is not examined; one byte per read
                        next_c.sda_oe = 1'b0;
                        next_c.state  = smbus_temp_pkg::ST_SKIP;
                    end else begin
                        next_c.tx     = {c.tx[6:0], 1'b0};
                        next_c.sda_oe = ~c.tx[6];
                        next_c.tx_cnt = c.tx_cnt + 1'b1;
                    end
                end
            end
            smbus_temp_pkg::ST_IDLE,
            smbus_temp_pkg::ST_SKIP: begin
                next_c.sda_oe = 1'b0;
            end
            default: begin
                next_c.state  = smbus_temp_pkg::ST_IDLE;
                next_c.sda_oe = 1'b0;
            end
        endcase

        // Stall watchdog; a hung host must not pin the data line low
        if (c.state != smbus_temp_pkg::ST_IDLE && !scl_s) begin
            if (c.stall == smbus_temp_pkg::STALL_W'(STALL_CYCLES - 1)) begin // [R20]
                next_c.state    = smbus_temp_pkg::ST_IDLE;
                next_c.sda_oe   = 1'b0;
                next_c.cfg_hold = 1'b0;
                next_c.stall    = '0;
            end else begin
                next_c.stall = c.stall + 1'b1;
            end
        end else begin
            next_c.stall = '0;
        end

        // Start and stop override the engine; any start aborts the frame in hand
        if (start_cond) begin
            next_c.state     = smbus_temp_pkg::ST_ADDR; // [R02]
            next_c.sda_oe    = 1'b0;
            next_c.frame_clr = 1'b1;
        end else if (stop_cond) begin
            next_c.state    = smbus_temp_pkg::ST_IDLE;
            next_c.sda_oe   = 1'b0;
            next_c.cfg_hold = 1'b0; // [R16]
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            c            <= '0;
            c.state      <= smbus_temp_pkg::ST_IDLE;
            c.after_ack  <= smbus_temp_pkg::ST_IDLE;
            // Edge history starts at the synchroniser's reset level: no false edge
            c.scl_d      <= 1'b0;
            c.sda_d      <= 1'b0;
            c.pointer    <= smbus_temp_pkg::PTR_RESET;
            c.config_reg <= smbus_temp_pkg::CONFIG_RESET;
        end else begin
            c <= next_c;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Conversion sequencing

    // Shutdown or a pending configuration write holds the converter idle
    assign conv_run = ~c.config_reg[smbus_temp_pkg::POWER_DOWN_POS] & ~c.cfg_hold; // [R13] [R17]

    conv_sequencer #(.CONV_CYCLES(CONV_CYCLES)) sequencer (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .run       (conv_run),
        .adc_code  (adc_code),
        .adc_fault (adc_fault),
        .result    (temp_result),
        .busy      (conv_busy)
    );

    assign sda_o        = c.sda_o;
    assign sda_oe       = c.sda_oe;
    assign converter_on = conv_busy;
endmodule

// File: tb/smbus_temp_chk.sv
`timescale 1ns/1ns
module smbus_temp_chk #(
    parameter int STALL_CYCLES = 400
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic scl,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe,
    input wire logic converter_on
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic [15:0] low_cnt;
    // Counts the clock-low span; a margin covers the input synchronizer
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            low_cnt <= 16'h0000;
        end else begin
            low_cnt <= scl ? 16'h0000 : low_cnt + 16'h0001;
        end
    end
    ////////////////////////////////////////////////////////////////
    property p_no_push;
        !sda_o;
    endproperty
    a_no_push: assert property (p_no_push) else $error("data pin pushed high");
    property p_rise_late;
        $rose(sda_oe) |-> !scl && !$past(scl, 2);
    endproperty
    a_rise_late: assert property (p_rise_late) else $error("drive began off clock low");
    property p_fall_late;
        $fell(sda_oe) |-> !scl && !$past(scl, 2);
    endproperty
    a_fall_late: assert property (p_fall_late) else $error("release off clock low");
    property p_hold_high;
        scl [*5] |-> $stable(sda_oe);
    endproperty
    a_hold_high: assert property (p_hold_high) else $error("drive moved in clock high");
    property p_quiet_stop;
        scl && $past(scl) && $rose(sda_i) |=> !sda_oe [*8];
    endproperty
    a_quiet_stop: assert property (p_quiet_stop) else $error("drive after stop");
    property p_stall;
        low_cnt > STALL_CYCLES + 10 |-> !sda_oe;
    endproperty
    a_stall: assert property (p_stall) else $error("line held past stall limit");
    property p_run_reset;
        $fell(rst) |-> ##[0:1] converter_on;
    endproperty
    a_run_reset: assert property (p_run_reset) else $error("no conversion after reset");
    property p_restart_idle;
        $rose(converter_on) |-> $past(scl, 2) && $past(sda_i, 2);
    endproperty
    a_restart_idle: assert property (p_restart_idle) else $error("restart not at stop");
endmodule
bind smbus_remote_temp_sensor smbus_temp_chk #(.STALL_CYCLES(STALL_CYCLES)) i_smbus_temp_chk (
    .ref_clk(ref_clk), .rst(rst), .scl(scl), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
    .converter_on(converter_on));

// File: tb/smbus_host_model.sv
`timescale 1ns/1ns
module smbus_host_model #(
    parameter int QUARTER = 64
) (
    input  wire logic ref_clk,
    input  wire logic sda,
    output logic      scl,
    output logic      sda_drv
);
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    task automatic wait_q();
        repeat (QUARTER) @(posedge ref_clk);
    endtask
    // Four quarters keep the clock period above its 2.5 us floor
    task automatic bit_io(input logic v, output logic s);
        wait_q();
        sda_drv <= v;
        wait_q();
        scl <= 1'b1;
        wait_q();
        s = sda;
        wait_q();
        scl <= 1'b0;
    endtask
    task automatic start_cond();
        sda_drv <= 1'b0;
        wait_q();
        scl <= 1'b0;
    endtask
    task automatic restart_cond();
        wait_q();
        sda_drv <= 1'b1;
        wait_q();
        scl <= 1'b1;
        wait_q();
        start_cond();
    endtask
    task automatic stop_cond();
        wait_q();
        sda_drv <= 1'b0;
        wait_q();
        scl <= 1'b1;
        wait_q();
        sda_drv <= 1'b1;
        wait_q();
    endtask
    task automatic send(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], s);
        end
        bit_io(1'b1, s);
        ack = !s;
    endtask
    task automatic write_byte(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d,
                              output logic ok);
        logic k0, k1, k2;
        start_cond();
        send({a, 1'b0}, k0);
        send(p, k1);
        send(d, k2);
        stop_cond();
        ok = k0 & k1 & k2;
    endtask
    task automatic read_byte(input logic [6:0] a, input logic [7:0] p, output logic [7:0] d,
                             output logic ok);
        logic k0, k1, k2, s;
        start_cond();
        send({a, 1'b0}, k0);
        send(p, k1);
        restart_cond();
        send({a, 1'b1}, k2);
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, d[i]);
        end
        bit_io(1'b1, s);
        stop_cond();
        ok = k0 & k1 & k2;
    endtask
    task automatic probe(input logic [6:0] a, output logic ok);
        start_cond();
        send({a, 1'b0}, ok);
        stop_cond();
    endtask
    // Holds the clock low inside the ack slot, sampling the line early and late
    task automatic stall_ack(input logic [6:0] a, input int n, output logic early,
                             output logic late);
        logic s;
        start_cond();
        for (int i = 6; i >= 0; i--) begin
            bit_io(a[i], s);
        end
        bit_io(1'b0, s);
        // Let go of the line, else the pull-up never shows and both samples read low
        repeat (2) @(posedge ref_clk);
        sda_drv <= 1'b1;
        repeat (8) @(posedge ref_clk);
        early = sda;
        repeat (n) @(posedge ref_clk);
        late = sda;
        stop_cond();
    endtask
endmodule

// File: tb/smbus_remote_temp_sensor_bench.sv
`timescale 1ns/1ns
module smbus_remote_temp_sensor_bench;
    localparam logic [2:0] SEL   = 3'h5;
    localparam logic [6:0] ADDR  = {smbus_temp_pkg::ADDR_HIGH, SEL};
    localparam logic [7:0] MAKER = 8'hA3; // Arbitrary value
    localparam logic [3:0] REV   = 4'hA;  // Arbitrary value
    logic       ref_clk;
    logic       rst;
    logic       scl;
    logic       sda_drv;
    logic       sda;
    logic       sda_o;
    logic       sda_oe;
    logic [7:0] adc_code;
    logic       adc_fault;
    logic       converter_on;
    logic       early;
    logic       late;
    logic       ok;
    int         failures;
    int         num_checks;
    // Open-drain wire with pull-up
    assign sda = sda_drv & ~sda_oe;
    smbus_remote_temp_sensor #(.ADDR_SEL(SEL), .MAKER_CODE(MAKER), .DIE_REV(REV),
        .CONV_CYCLES(50), .STALL_CYCLES(400)) i_smbus_remote_temp_sensor (
        .ref_clk(ref_clk), .rst(rst), .scl(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
        .adc_code(adc_code), .adc_fault(adc_fault), .converter_on(converter_on));
    smbus_host_model i_smbus_host_model (
        .ref_clk(ref_clk), .sda(sda), .scl(scl), .sda_drv(sda_drv));
    ////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("checks=%0d failures=%0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic rd(input logic [7:0] p, input logic [7:0] e);
        logic [7:0] d;
        logic       k;
        i_smbus_host_model.read_byte(ADDR, p, d, k);
        check({7'h00, k}, 8'h01);
        check(d, e);
    endtask
    task automatic wr(input logic [7:0] p, input logic [7:0] d);
        logic k;
        i_smbus_host_model.write_byte(ADDR, p, d, k);
        check({7'h00, k}, 8'h01);
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial begin
        // The full sequence takes about 88,600 cycles
        repeat (95000) @(posedge ref_clk);
        failures++;
        summarize();
    end
    initial begin
        rst = 1'b1;
        adc_code = 8'h00;
        adc_fault = 1'b0;
        failures = 0;
        num_checks = 0;
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (8) @(posedge ref_clk);
        rd(smbus_temp_pkg::PTR_CONFIG, 8'h80);
        rd(smbus_temp_pkg::PTR_MAKER, MAKER);
        rd(smbus_temp_pkg::PTR_REV, {4'h0, REV});
        adc_code <= 8'h80;
        rd(smbus_temp_pkg::PTR_TEMP, 8'h80);
        wr(smbus_temp_pkg::PTR_CONFIG, 8'h40);
        adc_code <= 8'h19;
        check({7'h00, converter_on}, 8'h00);
        rd(smbus_temp_pkg::PTR_TEMP, 8'h80);
        rd(smbus_temp_pkg::PTR_CONFIG, 8'h40);
        adc_fault <= 1'b1;
        wr(smbus_temp_pkg::PTR_CONFIG, 8'h00);
        repeat (8) @(posedge ref_clk);
        check({7'h00, converter_on}, 8'h01);
        rd(smbus_temp_pkg::PTR_TEMP, smbus_temp_pkg::TEMP_FULL_SCALE);
        i_smbus_host_model.probe(ADDR ^ 7'h01, ok);
        check({7'h00, ok}, 8'h00);
        i_smbus_host_model.stall_ack(ADDR, 500, early, late);
        check({7'h00, early}, 8'h00);
        check({7'h00, late}, 8'h01);
        summarize();
    end
endmodule
